// ### fbsio_pkg.sv
// Constants for the fieldbus slave state and process-data objects.
// Assumes a single device clock; imported by the register bank, the master model and the testbench.
`default_nettype none

package fbsio_pkg;

  // ****************************************************************
  // Object indices and subindices
  // ****************************************************************
  localparam logic [15:0] IDX_STATE_REQUEST = 16'h0120;
  localparam logic [15:0] IDX_STATE_REPORT  = 16'h0130;
  localparam logic [15:0] IDX_ERROR_CODE    = 16'h0134;
  localparam logic [15:0] IDX_INPUT_OBJ     = 16'h4000;
  localparam logic [15:0] IDX_IO_STATUS     = 16'h4001;
  localparam logic [15:0] IDX_OUTPUT_OBJ    = 16'h5000;
  localparam logic [7:0]  SUB_COUNT         = 8'h00;
  localparam logic [7:0]  SUB_LOW           = 8'h01;
  localparam logic [7:0]  SUB_HIGH          = 8'h02;
  localparam logic [7:0]  CNT_BYTE_OBJ      = 8'h02;
  localparam logic [7:0]  CNT_STATUS_OBJ    = 8'h01;

  // ****************************************************************
  // Field layout of the request and report words
  // ****************************************************************
  localparam int STATE_LSB = 0;
  localparam int STATE_MSB = 3;
  localparam int FLAG_BIT  = 4;
  localparam int IO_FAULTS = 6;

  // ****************************************************************
  // Device states and error codes
  // ****************************************************************
  typedef enum logic [3:0] {
    FBSIO_INIT   = 4'h1,
    FBSIO_PREOP  = 4'h2,
    FBSIO_BOOT   = 4'h3,
    FBSIO_SAFEOP = 4'h4,
    FBSIO_OP     = 4'h8
  } fbsio_state_t;

  localparam logic [15:0] ERR_NONE    = 16'h0000;
  localparam logic [15:0] ERR_INVALID = 16'h0011;
  localparam logic [15:0] ERR_UNKNOWN = 16'h0012;
  localparam logic [15:0] ERR_WATCHDOG = 16'h001b;

endpackage : fbsio_pkg

`default_nettype wire

// ### fbsio_regs.sv
// Device state machine, state registers and process-data objects.
// Assumes a master writes and reads objects by index and subindex on
// clk; pins din, io_fault and comm_fail are asynchronous.
//
// Contract
// RQ1: Request write starts matching state transition
// RQ2: Request field bits 0-3, five state codes
// RQ3: Bit 4 written one clears change flag
// RQ4: Master writes reserved bits 5-7 as zero
// RQ5: Report bits 0-3 show current state
// RQ6: Flag set on change/error, clear on confirm
// RQ7: Error code register holds 16-bit code
// RQ8: Refused transition sets flag and code
// RQ9: Codes 0x11 invalid, 0x12 unknown, state kept
// RQ10: Leaving operational drives substitute outputs
// RQ11: Input object two bytes, count two
// RQ12: Status word bits 0-5 flag supply faults
// RQ13: Output object two bytes, count two
`timescale 1ns/10ps
`default_nettype none

module fbsio_regs
  import fbsio_pkg::*;
#(
  parameter logic [15:0] SAFE_VALUE = 16'h0000
)(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] obj_index,
  input  wire logic [7:0]  obj_sub,
  input  wire logic        obj_wr,
  input  wire logic        obj_rd,
  input  wire logic [15:0] obj_wdata,
  output var  logic [31:0] obj_rdata,
  input  wire logic [15:0] din,
  input  wire logic [5:0]  io_fault,
  input  wire logic        comm_fail,
  output var  logic [15:0] dout
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int SW = 16 + IO_FAULTS + 1;

  logic [SW-1:0] s1_q, s2_q, s3_q, pins_q;
  logic          unused_rsv;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      pins_q <= '0;
    end
    else
    begin
      s1_q <= {comm_fail, io_fault, din};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < SW; i++)
        if (s2_q[i] == s3_q[i])
          pins_q[i] <= s3_q[i];
    end
  end

  wire logic [15:0] in_bits  = pins_q[15:0];
  wire logic [5:0]  faults   = pins_q[16 +: IO_FAULTS];
  wire logic        fail_s   = pins_q[SW-1];

  // ****************************************************************
  // Transition checks
  // ****************************************************************
  function automatic logic known_code(input logic [3:0] c);
    known_code = (c == FBSIO_INIT) || (c == FBSIO_PREOP) ||
                 (c == FBSIO_BOOT) || (c == FBSIO_SAFEOP) ||
                 (c == FBSIO_OP);
  endfunction

  // Allowed moves; staying in a state is always allowed
  function automatic logic move_ok(input fbsio_state_t cur,
                                   input logic [3:0]   req);
    unique case (cur)
      FBSIO_INIT:   move_ok = (req == FBSIO_INIT) ||
                              (req == FBSIO_PREOP) || (req == FBSIO_BOOT);
      FBSIO_PREOP:  move_ok = (req == FBSIO_INIT) ||
                              (req == FBSIO_PREOP) || (req == FBSIO_SAFEOP);
      FBSIO_BOOT:   move_ok = (req == FBSIO_INIT) || (req == FBSIO_BOOT);
      FBSIO_SAFEOP,
      FBSIO_OP:     move_ok = (req != FBSIO_BOOT);
    endcase
  endfunction

  // ****************************************************************
  // Decode of the request write
  // ****************************************************************
  fbsio_state_t state_q, state_d;
  logic [3:0]   req_q;
  logic         ack_q, flag_q, flag_d;
  logic [15:0]  code_q, code_d, out_obj_q;

  wire logic       wr_ctl    = obj_wr && (obj_index == IDX_STATE_REQUEST);
  wire logic [3:0] req_code  = obj_wdata[STATE_MSB:STATE_LSB];     // RQ2
  wire logic       ack_bit   = obj_wdata[FLAG_BIT];                // RQ3
  wire logic       req_known = known_code(req_code);
  wire logic       req_ok    = req_known && move_ok(state_q, req_code);
  wire logic       comm_lost = fail_s && (state_q == FBSIO_OP);
  wire logic       take_req  = wr_ctl && req_ok && !comm_lost;
  wire logic       refuse    = wr_ctl && !req_ok && !comm_lost;    // RQ8
  wire logic       flag_set  = comm_lost || refuse;                // RQ6
  wire logic       flag_clr  = wr_ctl && (ack_bit || req_ok);      // RQ3
  assign unused_rsv = ^obj_wdata[15:FLAG_BIT+1];                   // RQ4

  // Next state: communication loss outranks a master request
  always_comb
  begin
    state_d = state_q;
    if (comm_lost)
      state_d = FBSIO_SAFEOP;                                      // RQ10
    else if (take_req)
      state_d = fbsio_state_t'(req_code);                          // RQ1
  end

  // Set beats clear so no event is lost
  assign flag_d = flag_set || (flag_q && !flag_clr);               // RQ6

  // Error code follows the outcome of the last event
  always_comb
  begin
    code_d = code_q;
    if (comm_lost)
      code_d = ERR_WATCHDOG;
    else if (refuse && !req_known)
      code_d = ERR_UNKNOWN;                                        // RQ9
    else if (refuse)
      code_d = ERR_INVALID;                                        // RQ9
    else if (take_req)
      code_d = ERR_NONE;                                           // RQ7
  end

  // ****************************************************************
  // State registers and output object
  // ****************************************************************
  wire logic wr_out_lo = obj_wr && (obj_index == IDX_OUTPUT_OBJ) &&
                         (obj_sub == SUB_LOW);
  wire logic wr_out_hi = obj_wr && (obj_index == IDX_OUTPUT_OBJ) &&
                         (obj_sub == SUB_HIGH);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q   <= FBSIO_INIT;
      req_q     <= FBSIO_INIT;
      ack_q     <= 1'b0;
      flag_q    <= 1'b0;
      code_q    <= ERR_NONE;
      out_obj_q <= '0;
    end
    else
    begin
      state_q <= state_d;                                          // RQ1
      flag_q  <= flag_d;
      code_q  <= code_d;                                           // RQ7
      if (wr_ctl)
      begin
        req_q <= req_code;
        ack_q <= ack_bit;
      end
      if (wr_out_lo)
        out_obj_q[7:0] <= obj_wdata[7:0];                          // RQ13
      if (wr_out_hi)
        out_obj_q[15:8] <= obj_wdata[7:0];                         // RQ13
    end
  end

  // Pins take substitute values outside the operational state
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      dout <= SAFE_VALUE;
    else
      dout <= (state_q == FBSIO_OP) ? out_obj_q : SAFE_VALUE;      // RQ10
  end

  // ****************************************************************
  // Read decode
  // ****************************************************************
  wire logic [31:0] rd_ctl    = {27'h0, ack_q, req_q};
  wire logic [31:0] rd_report = {27'h0, flag_q, state_q};          // RQ5
  wire logic [31:0] rd_code   = {16'h0, code_q};                   // RQ7
  wire logic [31:0] rd_cnt2   = {24'h0, CNT_BYTE_OBJ};
  wire logic [31:0] rd_in     = (obj_sub == SUB_COUNT) ? rd_cnt2 :
                                (obj_sub == SUB_LOW)
                                  ? {24'h0, in_bits[7:0]} :
                                (obj_sub == SUB_HIGH)
                                  ? {24'h0, in_bits[15:8]} : 32'h0; // RQ11
  wire logic [31:0] rd_stat   = (obj_sub == SUB_COUNT)
                                  ? {24'h0, CNT_STATUS_OBJ} :
                                (obj_sub == SUB_LOW)
                                  ? {26'h0, faults} : 32'h0;       // RQ12
  wire logic [31:0] rd_out    = (obj_sub == SUB_COUNT) ? rd_cnt2 :
                                (obj_sub == SUB_LOW)
                                  ? {24'h0, out_obj_q[7:0]} :
                                (obj_sub == SUB_HIGH)
                                  ? {24'h0, out_obj_q[15:8]} : 32'h0; // RQ13
  wire logic [31:0] rd_mux    =
    (obj_index == IDX_STATE_REQUEST) ? rd_ctl :
    (obj_index == IDX_STATE_REPORT)  ? rd_report :
    (obj_index == IDX_ERROR_CODE)    ? rd_code :
    (obj_index == IDX_INPUT_OBJ)     ? rd_in :
    (obj_index == IDX_IO_STATUS)     ? rd_stat :
    (obj_index == IDX_OUTPUT_OBJ)    ? rd_out : 32'h0;

  // Read data is captured at the edge that takes the strobe and then held
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      obj_rdata <= '0;
    else if (obj_rd)
      obj_rdata <= rd_mux;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_take_request: assert property (take_req |=>                    // RQ1
      state_q == $past(req_code)) else $error("Request not taken");
  a_unknown_code: assert property (refuse && !req_known |=>        // RQ9
      code_q == ERR_UNKNOWN && state_q == $past(state_q) && flag_q)
    else $error("Unknown state not reported");
  a_invalid_code: assert property (refuse && req_known |=>         // RQ8
      code_q == ERR_INVALID && flag_q && $stable(state_q))
    else $error("Invalid move not reported");
  a_ack_clears: assert property (wr_ctl && ack_bit && !flag_set |=> // RQ3
      !flag_q) else $error("Acknowledge did not clear flag");
  a_set_wins: assert property (flag_set |=> flag_q)                // RQ6
    else $error("Flag event lost");
  a_confirm_clear: assert property (take_req |=>                   // RQ6
      !flag_q && code_q == ERR_NONE) else $error("No confirmation");
  a_comm_drop: assert property (comm_lost |=> state_q == FBSIO_SAFEOP
      ##1 dout == SAFE_VALUE) else $error("No substitute on loss"); // RQ10
  a_safe_outputs: assert property (state_q != FBSIO_OP |=>         // RQ10
      dout == SAFE_VALUE) else $error("Outputs live outside op");
  a_report_read: assert property (obj_rd &&                        // RQ5
      obj_index == IDX_STATE_REPORT |=>
      obj_rdata[3:0] == $past(state_q) && obj_rdata[31:5] == '0)
    else $error("Report read wrong");
  a_input_read: assert property (obj_rd && obj_index == IDX_INPUT_OBJ
      && obj_sub == SUB_HIGH |=>
      obj_rdata == {24'h0, $past(in_bits[15:8])})                  // RQ11
    else $error("Input byte read wrong");
  a_status_read: assert property (obj_rd && obj_index == IDX_IO_STATUS
      && obj_sub == SUB_LOW |=> obj_rdata[31:6] == '0)             // RQ12
    else $error("Status reserved bits set");

  c_reach_op:   cover property (state_q == FBSIO_OP);
  c_refused:    cover property (refuse ##1 wr_ctl && ack_bit);
  c_comm_loss:  cover property (comm_lost);
  c_set_vs_clr: cover property (flag_set && flag_clr);

endmodule // fbsio_regs

`default_nettype wire

// ### fbsio_master.sv
// Master model that reaches the slave objects by index and subindex.
// Assumes the bank samples its strobes on the rising edge of clk.
`timescale 1ns/10ps
`default_nettype none

module fbsio_master
  import fbsio_pkg::*;
(
  input  wire logic        clk,
  output var  logic [15:0] obj_index,
  output var  logic [7:0]  obj_sub,
  output var  logic        obj_wr,
  output var  logic        obj_rd,
  output var  logic [15:0] obj_wdata,
  input  wire logic [31:0] obj_rdata
);
  // Idle port: strobes low, qualifiers hold no useful value
  initial
  begin
    obj_index = 16'hffff;
    obj_sub   = 8'hff;
    obj_wr    = 1'b0;
    obj_rd    = 1'b0;
    obj_wdata = 16'hffff;
  end

  // One-cycle write strobe, index and data scrambled once it is taken
  task automatic wr_obj(input logic [15:0] idx, input logic [7:0] sub,
                        input logic [15:0] data);
    @(posedge clk);
    #2;
    obj_index = idx;
    obj_sub   = sub;
    obj_wdata = (idx == IDX_STATE_REQUEST) ? (data & 16'h001f) : data;
    obj_wr    = 1'b1;
    @(posedge clk);
    #2;
    obj_wr    = 1'b0;
    obj_wdata = ~obj_wdata;
    obj_index = ~idx;
  endtask

  // One-cycle read strobe; data is registered at the taking edge
  task automatic rd_obj(input logic [15:0] idx, input logic [7:0] sub,
                        output logic [31:0] data);
    @(posedge clk);
    #2;
    obj_index = idx;
    obj_sub   = sub;
    obj_rd    = 1'b1;
    @(posedge clk);
    #2;
    obj_rd    = 1'b0;
    obj_index = ~idx;
    data      = obj_rdata;
  endtask
endmodule // fbsio_master

`default_nettype wire

// ### test_fieldbus_state_and_io_objects.sv
// Testbench for the slave state registers and process-data objects.
// Assumes the master model drives the object port; pins come from here.
`timescale 1ns/10ps
`default_nettype none

module test_fieldbus_state_and_io_objects
  import fbsio_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic [15:0] obj_index;
  logic [7:0]  obj_sub;
  logic        obj_wr;
  logic        obj_rd;
  logic [15:0] obj_wdata;
  logic [31:0] obj_rdata;
  logic [15:0] din;
  logic [5:0]  io_fault;
  logic        comm_fail;
  logic [15:0] dout;
  logic [31:0] v;
  int          fail_count;
  int          check_count;
  int          cycles;

  fbsio_regs dut_u (.clk(clk), .rst_b(rst_b), .obj_index(obj_index),
    .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .din(din),
    .io_fault(io_fault), .comm_fail(comm_fail), .dout(dout));
  fbsio_master master_u (.clk(clk), .obj_index(obj_index),
    .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd),
    .obj_wdata(obj_wdata), .obj_rdata(obj_rdata));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // Read one object and compare it
  task automatic rd_chk(input string name, input logic [15:0] idx,
                        input logic [7:0] sub, input logic [31:0] exp);
    master_u.rd_obj(idx, sub, v);
    check(name, v, exp);
  endtask

  // Main sequence
  initial
  begin
    rst_b     = 1'b0;
    din       = 16'h1234;
    io_fault  = 6'h2a;
    comm_fail = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    rst_b = 1'b1;
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h01);
    rd_chk("code", IDX_ERROR_CODE, SUB_COUNT, 32'h0);
    rd_chk("request", IDX_STATE_REQUEST, SUB_COUNT, 32'h01);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0002);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h02);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0008);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h12);
    rd_chk("code", IDX_ERROR_CODE, SUB_COUNT, 32'h11);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0005);
    rd_chk("code", IDX_ERROR_CODE, SUB_COUNT, 32'h12);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h12);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0015);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h12);
    rd_chk("request", IDX_STATE_REQUEST, SUB_COUNT, 32'h15);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0012);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h02);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0001);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h01);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0003);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h03);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0004);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h13);
    rd_chk("code", IDX_ERROR_CODE, SUB_COUNT, 32'h11);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0011);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h01);
    rd_chk("request", IDX_STATE_REQUEST, SUB_COUNT, 32'h11);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0002);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0004);
    master_u.wr_obj(IDX_STATE_REQUEST, SUB_COUNT, 16'h0008);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h08);
    rd_chk("code", IDX_ERROR_CODE, SUB_COUNT, 32'h0);
    rd_chk("in count", IDX_INPUT_OBJ, SUB_COUNT, 32'h02);
    rd_chk("in low", IDX_INPUT_OBJ, SUB_LOW, 32'h34);
    rd_chk("in high", IDX_INPUT_OBJ, SUB_HIGH, 32'h12);
    rd_chk("st count", IDX_IO_STATUS, SUB_COUNT, 32'h01);
    rd_chk("status", IDX_IO_STATUS, SUB_LOW, 32'h2a);
    rd_chk("out count", IDX_OUTPUT_OBJ, SUB_COUNT, 32'h02);
    rd_chk("unmapped", 16'h6000, SUB_COUNT, 32'h0);
    master_u.wr_obj(IDX_OUTPUT_OBJ, SUB_LOW, 16'h00aa);
    master_u.wr_obj(IDX_OUTPUT_OBJ, SUB_HIGH, 16'h0055);
    repeat (2) @(posedge clk);
    #2;
    check("dout", {16'h0, dout}, 32'h55aa);
    rd_chk("out low", IDX_OUTPUT_OBJ, SUB_LOW, 32'haa);
    comm_fail = 1'b1;
    repeat (10) @(posedge clk);
    #2;
    check("dout", {16'h0, dout}, 32'h0);
    rd_chk("report", IDX_STATE_REPORT, SUB_COUNT, 32'h14);
    rd_chk("code", IDX_ERROR_CODE, SUB_COUNT, 32'h1b);
    stop_test();
  end
endmodule // test_fieldbus_state_and_io_objects

`default_nettype wire
